//--- rtl/sebt_pkg.sv
// Constants and types shared by the serial memory bus target.
package sebt_pkg;

  // Marks of the bit counter within one nine-clock word.
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // Page buffer and address layout.
  localparam int PAGE_BYTES = 64;
  localparam logic [6:0] PAGE_END = 7'h40;
  localparam logic [6:0] IDX_RST = 7'h00;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] TMR_RST = 16'h0000;

  // Fastest serial clock the sampling logic is sized for.
  localparam int SCL_MAX_KHZ = 400;

  // Longest programming cycle, in its own unit and in core cycles.
  // The stop detection and both crossings add a few cycles around the
  // timer, so the timer runs a little short to keep the whole cycle
  // from stop to standby within the limit.
  localparam int CORE_CLK_KHZ = 10000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_MARGIN = 16;
  localparam int PROG_CYCLES = PROG_TIME_MS * CORE_CLK_KHZ - PROG_MARGIN;

  // Sampled bus pins.
  typedef struct packed {
    logic scl;
    logic sda;
  } sebt_bus_t;

  // One byte handed to the memory array.
  typedef struct packed {
    logic en;
    logic [14:0] addr;
    logic [7:0] data;
  } sebt_mwr_t;

  // Link state machine, Gray coded along the write path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b011,
    ST_ALO = 3'b010,
    ST_WDAT = 3'b110,
    ST_RDAT = 3'b111,
    ST_RWAIT = 3'b101,
    ST_PROG = 3'b100
  } sebt_state_t;

endpackage

//--- rtl/sebt_top.sv
// Two-wire serial memory bus target with page buffer and program timer.
`timescale 1ns/100ps
module sebt_top
  import sebt_pkg::*;
#(
  // Device type code; the default value is arbitrary.
  parameter logic [3:0] TYPE_CODE = 4'h5,
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen,
  input wire logic [2:0] select_strap_pins,
  input wire logic write_lock,
  output logic [14:0] link_rd_addr,
  input wire logic [7:0] link_rd_data,
  output logic prog_busy,
  output sebt_mwr_t mem_wr
);

  localparam logic [15:0] TMR_LAST = 16'(PROG_CYCLES_P - 1);

  // ------------------------------------------------------------
  // Crossings into the link domain
  // ------------------------------------------------------------

  logic lrst1_r;
  logic lrst_n_r;
  sebt_bus_t bus1_r;
  sebt_bus_t bus_r;
  sebt_bus_t busd_r;
  logic [2:0] strap1_r;
  logic [2:0] strap_r;
  logic lock1_r;
  logic lock_r;
  logic busy1_r;
  logic busy_r;
  logic pbusy_r;

  // Pins and the busy level each pass two flops before use.
  // A third bus flop gives the previous sample for edge detection.
  always_ff @(posedge link_clk) begin
    lrst1_r <= resetn;
    lrst_n_r <= lrst1_r;
    bus1_r <= '{scl: scl_i, sda: sda_i};
    bus_r <= bus1_r;
    busd_r <= bus_r;
    strap1_r <= select_strap_pins;
    strap_r <= strap1_r;
    lock1_r <= write_lock;
    lock_r <= lock1_r;
    busy1_r <= pbusy_r;
    busy_r <= busy1_r;
  end

  // ------------------------------------------------------------
  // Bus events
  // ------------------------------------------------------------

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // Oversampling at the link rate leaves dozens of samples per
  // serial clock phase, so edges are never missed.
  assign scl_rise = bus_r.scl & ~busd_r.scl;
  assign scl_fall = ~bus_r.scl & busd_r.scl;
  // Data moves only with the clock low, so data edges under a high
  // clock are always start or stop.
  assign start_ev = bus_r.scl & busd_r.scl & busd_r.sda & ~bus_r.sda;
  assign stop_ev = bus_r.scl & busd_r.scl & ~busd_r.sda & bus_r.sda;

  // ------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------

  sebt_state_t st_r;
  sebt_state_t st_nxt;
  logic [3:0] bcnt_r;
  logic [3:0] bcnt_nxt;
  logic [7:0] shr_r;
  logic [7:0] shr_nxt;
  logic [7:0] txr_r;
  logic [7:0] txr_nxt;
  logic [7:0] ahi_r;
  logic [7:0] ahi_nxt;
  logic [14:0] addr_r;
  logic [14:0] addr_nxt;
  logic oen_r;
  logic oen_nxt;
  logic mack_r;
  logic mack_nxt;
  logic req_r;
  logic req_nxt;
  logic seen_r;
  logic seen_nxt;
  logic [63:0] vld_r;
  logic [63:0] vld_nxt;
  logic [7:0] buf_r [PAGE_BYTES];
  logic [7:0] buf_nxt [PAGE_BYTES];
  logic dev_hit;

  // Type code and select code must both match.
  assign dev_hit = (shr_r[7:4] == TYPE_CODE) && (shr_r[3:1] == strap_r);

  // Next state of the link: bits in on rise, line changes on fall.
  always_comb begin
    st_nxt = st_r;
    bcnt_nxt = bcnt_r;
    shr_nxt = shr_r;
    txr_nxt = txr_r;
    ahi_nxt = ahi_r;
    addr_nxt = addr_r;
    oen_nxt = oen_r;
    mack_nxt = mack_r;
    req_nxt = req_r;
    seen_nxt = seen_r;
    vld_nxt = vld_r;
    buf_nxt = buf_r;
    if (st_r == ST_PROG) begin
      // The bus is ignored, so polling gets no answer.
      if (busy_r) begin
        seen_nxt = 1'b1;
      end else if (seen_r) begin
        st_nxt = ST_IDLE;
        seen_nxt = 1'b0;
      end
    end else if (start_ev) begin
      st_nxt = ST_DEV;
      bcnt_nxt = BIT_RST;
      oen_nxt = 1'b1;
    end else if (stop_ev) begin
      oen_nxt = 1'b1;
      bcnt_nxt = BIT_RST;
      if (st_r == ST_WDAT && (|vld_r) && !lock_r) begin
        st_nxt = ST_PROG;
        req_nxt = ~req_r;
        seen_nxt = 1'b0;
      end else begin
        st_nxt = ST_IDLE;
      end
    end else if (st_r != ST_IDLE) begin
      if (scl_rise) begin
        if (bcnt_r < BIT_ACK) begin
          shr_nxt = {shr_r[6:0], bus_r.sda};
          bcnt_nxt = bcnt_r + 4'h1;
        end else if (bcnt_r == BIT_ACK) begin
          mack_nxt = ~bus_r.sda;
          bcnt_nxt = BIT_DONE;
          if (st_r == ST_RDAT) begin
            addr_nxt = addr_r + 15'h0001;
          end
        end
      end else if (scl_fall) begin
        if (bcnt_r == BIT_ACK) begin
          // Ninth clock: receiver answers, transmitter lets go.
          case (st_r)
            ST_DEV: begin
              if (dev_hit) begin
                oen_nxt = 1'b0;
              end else begin
                st_nxt = ST_IDLE;
              end
            end
            ST_AHI, ST_ALO: begin
              oen_nxt = 1'b0;
            end
            ST_WDAT: begin
              oen_nxt = lock_r;
            end
            default: begin
              oen_nxt = 1'b1;
            end
          endcase
        end else if (bcnt_r == BIT_DONE) begin
          oen_nxt = 1'b1;
          bcnt_nxt = BIT_RST;
          case (st_r)
            ST_DEV: begin
              if (shr_r[0]) begin
                st_nxt = ST_RDAT;
                txr_nxt = link_rd_data;
                oen_nxt = link_rd_data[7];
              end else begin
                st_nxt = ST_AHI;
                vld_nxt = '0;
              end
            end
            ST_AHI: begin
              ahi_nxt = shr_r;
              st_nxt = ST_ALO;
            end
            ST_ALO: begin
              addr_nxt = {ahi_r[6:0], shr_r};
              st_nxt = ST_WDAT;
            end
            ST_WDAT: begin
              if (oen_r) begin
                st_nxt = ST_IDLE;
              end else begin
                buf_nxt[addr_r[5:0]] = shr_r;
                vld_nxt[addr_r[5:0]] = 1'b1;
                // Low six bits only, so the page wraps.
                addr_nxt = {addr_r[14:6], addr_r[5:0] + 6'h01};
              end
            end
            ST_RDAT: begin
              if (mack_r) begin
                txr_nxt = link_rd_data;
                oen_nxt = link_rd_data[7];
              end else begin
                st_nxt = ST_RWAIT;
              end
            end
            default: begin
              oen_nxt = 1'b1;
            end
          endcase
        end else if (st_r == ST_RDAT) begin
          oen_nxt = txr_r[3'h7 - bcnt_r[2:0]];
        end
      end
    end
  end

  // Link registers.
  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      st_r <= ST_IDLE;
      bcnt_r <= BIT_RST;
      shr_r <= BYTE_RST;
      txr_r <= BYTE_RST;
      ahi_r <= BYTE_RST;
      addr_r <= ADDR_RST;
      oen_r <= 1'b1;
      mack_r <= 1'b0;
      req_r <= 1'b0;
      seen_r <= 1'b0;
      vld_r <= '0;
      buf_r <= '{default: BYTE_RST};
    end else begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      shr_r <= shr_nxt;
      txr_r <= txr_nxt;
      ahi_r <= ahi_nxt;
      addr_r <= addr_nxt;
      oen_r <= oen_nxt;
      mack_r <= mack_nxt;
      req_r <= req_nxt;
      seen_r <= seen_nxt;
      vld_r <= vld_nxt;
      buf_r <= buf_nxt;
    end
  end

  // The pin only ever pulls low; the pull-up makes the high.
  assign sda_o = 1'b0;
  assign sda_oen = oen_r;
  assign link_rd_addr = addr_r;

  // ------------------------------------------------------------
  // Programming cycle in the core domain
  // ------------------------------------------------------------

  logic req1_r;
  logic req2_r;
  logic reqd_r;
  logic reqd_nxt;
  logic pbusy_nxt;
  logic [15:0] tmr_r;
  logic [15:0] tmr_nxt;
  logic [6:0] widx_r;
  logic [6:0] widx_nxt;
  sebt_mwr_t mwr_r;
  sebt_mwr_t mwr_nxt;

  // Request toggle crossing from the link domain.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      req1_r <= 1'b0;
      req2_r <= 1'b0;
    end else begin
      req1_r <= req_r;
      req2_r <= req1_r;
    end
  end

  // The page buffer is read here while the link sits idle in its
  // programming state, so the words are stable for the whole walk.
  always_comb begin
    reqd_nxt = reqd_r;
    pbusy_nxt = pbusy_r;
    tmr_nxt = tmr_r;
    widx_nxt = widx_r;
    mwr_nxt = '{en: 1'b0, addr: mwr_r.addr, data: mwr_r.data};
    if (!pbusy_r) begin
      if (req2_r != reqd_r) begin
        reqd_nxt = req2_r;
        pbusy_nxt = 1'b1;
        tmr_nxt = TMR_RST;
        widx_nxt = IDX_RST;
      end
    end else begin
      tmr_nxt = tmr_r + 16'h0001;
      if (widx_r < PAGE_END) begin
        widx_nxt = widx_r + 7'h01;
        if (vld_r[widx_r[5:0]]) begin
          mwr_nxt = '{en: 1'b1,
                      addr: {addr_r[14:6], widx_r[5:0]},
                      data: buf_r[widx_r[5:0]]};
        end
      end
      if (tmr_r >= TMR_LAST && widx_r == PAGE_END) begin
        pbusy_nxt = 1'b0;
      end
    end
  end

  // Core registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reqd_r <= 1'b0;
      pbusy_r <= 1'b0;
      tmr_r <= TMR_RST;
      widx_r <= IDX_RST;
      mwr_r <= '{en: 1'b0, addr: ADDR_RST, data: BYTE_RST};
    end else begin
      reqd_r <= reqd_nxt;
      pbusy_r <= pbusy_nxt;
      tmr_r <= tmr_nxt;
      widx_r <= widx_nxt;
      mwr_r <= mwr_nxt;
    end
  end

  assign prog_busy = pbusy_r;
  assign mem_wr = mwr_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  sequence s_word_end;
    scl_fall && !start_ev && !stop_ev && bcnt_r == BIT_ACK;
  endsequence

  sequence s_ack_end;
    scl_fall && !start_ev && !stop_ev && bcnt_r == BIT_DONE;
  endsequence

  chk_drive_on_fall: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    $fell(sda_oen) |-> $past(scl_fall))
    else $error("Data line pulled low without a clock fall.");

  chk_open_drain: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    !sda_oen |-> sda_o == 1'b0 && st_r != ST_IDLE && st_r != ST_PROG
                 && st_r != ST_RWAIT)
    else $error("Data line pulled low outside a transfer.");

  chk_start_enter: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    start_ev && st_r != ST_PROG |=> st_r == ST_DEV && bcnt_r == BIT_RST)
    else $error("Start not taken as a new transaction.");

  chk_stop_read: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    stop_ev && (st_r == ST_RDAT || st_r == ST_RWAIT)
    |=> st_r == ST_IDLE && sda_oen)
    else $error("Stop after read did not reach standby.");

  chk_stop_prog: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    stop_ev && st_r == ST_WDAT && (|vld_r) && !lock_r
    |=> st_r == ST_PROG && req_r != $past(req_r))
    else $error("Stop after write data did not start programming.");

  chk_dev_ack: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    s_word_end ##0 (st_r == ST_DEV && dev_hit) |=> !sda_oen [*4])
    else $error("Matching address word not acknowledged.");

  chk_dev_miss: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    s_word_end ##0 (st_r == ST_DEV && !dev_hit)
    |=> st_r == ST_IDLE && sda_oen)
    else $error("Mismatched address word not ignored.");

  chk_write_ack: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    s_word_end ##0 st_r == ST_WDAT |=> sda_oen == $past(lock_r))
    else $error("Write data answer does not follow the lock.");

  chk_read_msb: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    s_ack_end ##0 (st_r == ST_DEV && shr_r[0])
    |=> st_r == ST_RDAT && sda_oen == txr_r[7])
    else $error("Read byte did not open with its top bit.");

  chk_read_quiet: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    st_r == ST_RWAIT |-> sda_oen)
    else $error("Data line driven after a refused read byte.");

  chk_prog_quiet: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    st_r == ST_PROG |-> sda_oen && $stable(addr_r))
    else $error("Bus answered during programming.");

  chk_page_wrap: assert property (
    @(posedge link_clk) disable iff (!lrst_n_r)
    s_ack_end ##0 (st_r == ST_WDAT && !oen_r)
    |=> addr_r[14:6] == $past(addr_r[14:6])
        && addr_r[5:0] == $past(addr_r[5:0]) + 6'h01)
    else $error("Page offset did not step within its page.");

  chk_prog_bound: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $fell(pbusy_r) |-> $past(tmr_r) == TMR_LAST)
    else $error("Programming cycle length is wrong.");

endmodule

//--- sim/sebt_ctl_model.sv
// Behavioural two-wire bus controller that drives the memory target.
`timescale 1ns/100ps
module sebt_ctl_model (
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // --------------------------------------------------------------------
  // Bit timing
  // --------------------------------------------------------------------
  // A 2600 ns bit keeps the serial clock below its fastest legal rate.
  localparam int QTR_NS = 650;

  // Idle bus: clock high and data released, so the clock stands still.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // --------------------------------------------------------------------
  // Bus conditions and transfers
  // --------------------------------------------------------------------
  // Data falls while the clock is high; works from idle or after a bit.
  task automatic start();
    #(QTR_NS);
    sda_drv = 1'b1;
    #(QTR_NS);
    scl = 1'b1;
    #(QTR_NS);
    sda_drv = 1'b0;
    #(QTR_NS);
    scl = 1'b0;
  endtask

  // Data rises while the clock is high, then the bus is left idle.
  task automatic stop();
    #(QTR_NS);
    sda_drv = 1'b0;
    #(QTR_NS);
    scl = 1'b1;
    #(QTR_NS);
    sda_drv = 1'b1;
    #(4 * QTR_NS);
  endtask

  // Data changes only in mid low phase; the wire is read mid high phase.
  task automatic bit_xfer(input logic b, output logic smp);
    #(QTR_NS);
    sda_drv = b;
    #(QTR_NS);
    scl = 1'b1;
    #(QTR_NS);
    smp = sda;
    #(QTR_NS);
    scl = 1'b0;
  endtask

  // Eight bits out, then the line is released for the ninth clock.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, ack);
  endtask

  // Eight bits in, then our own answer on the ninth clock.
  task automatic rd_byte(input logic mack, output logic [7:0] d,
                         output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(mack, s);
  endtask
endmodule

//--- sim/test_sebt_top.sv
// Self-checking testbench for the serial memory bus target.
`timescale 1ns/100ps
module test_sebt_top;
  import sebt_pkg::*;
  // Type code handed to the design; the value is arbitrary.
  localparam logic [3:0] TYPE = 4'h5;
  localparam int PROG = 500;
  logic core_clk, link_clk, resetn, scl, sda_drv, sda, sda_o, sda_oen;
  logic write_lock, prog_busy;
  logic [2:0] select_strap_pins;
  logic [14:0] link_rd_addr;
  logic [7:0] link_rd_data;
  sebt_mwr_t mem_wr;
  logic [7:0] wr_mem [logic [14:0]];
  int wr_cnt = 0;
  int busy_len = 0;
  int miscompares = 0;
  int total_checks = 0;

  // --------------------------------------------------------------------
  // Clocks, wire and design
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // Wired-AND with the pull-up: either party may only pull low.
  assign sda = sda_drv & (sda_oen ? 1'b1 : sda_o);

  // Array contents seen by reads; asymmetric so bit order shows.
  function automatic logic [7:0] rd_val(input logic [14:0] a);
    return a[7:0] + 8'h5A;
  endfunction
  assign link_rd_data = rd_val(link_rd_addr);

  sebt_top #(.TYPE_CODE(TYPE), .PROG_CYCLES_P(PROG)) sebt_top_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .link_clk(link_clk),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oen(sda_oen),
    .select_strap_pins(select_strap_pins),
    .write_lock(write_lock),
    .link_rd_addr(link_rd_addr),
    .link_rd_data(link_rd_data),
    .prog_busy(prog_busy),
    .mem_wr(mem_wr)
  );
  sebt_ctl_model sebt_ctl_model_i (.sda(sda), .scl(scl), .sda_drv(sda_drv));

  // --------------------------------------------------------------------
  // Monitors and helpers
  // --------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Committed bytes and programming length, both in the core domain.
  always @(posedge core_clk) begin
    if (mem_wr.en === 1'b1) begin
      wr_mem[mem_wr.addr] = mem_wr.data;
      wr_cnt++;
    end
    if (prog_busy === 1'b1) busy_len++;
  end

  // The device may only move its drive while the clock pin is low.
  always @(sda_oen) begin
    if (resetn === 1'b1) begin
      check("oen_scl_low", 16'(scl), 16'h0000);
      check("drive_level", 16'(sda_o), 16'h0000);
    end
  end

  task automatic clr();
    wr_mem.delete();
    wr_cnt = 0;
    busy_len = 0;
  endtask

  task automatic addr_w(input logic [7:0] w, input logic exp,
                        input string nm);
    logic a;
    sebt_ctl_model_i.wr_byte(w, a);
    check(nm, 16'(a), 16'(exp));
  endtask

  // Bounded wait, so a stuck flag fails instead of hanging.
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 2000 && prog_busy !== lvl; n++) begin
      @(negedge core_clk);
    end
    check("prog_busy", 16'(prog_busy), 16'(lvl));
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Every strap value with its matching and a mismatching select, then a mismatching type code.
  task automatic t_select();
    for (int s = 0; s < 8; s++) begin
      @(negedge core_clk) select_strap_pins = 3'(s);
      repeat (5) @(negedge core_clk);
      sebt_ctl_model_i.start();
      addr_w({TYPE, 3'(s), 1'b0}, 1'b0, "sel_ack");
      sebt_ctl_model_i.start();
      addr_w({TYPE, 3'(s) ^ 3'h4, 1'b0}, 1'b1, "sel_nak");
      sebt_ctl_model_i.stop();
    end
    @(negedge core_clk) select_strap_pins = 3'h2;
    repeat (5) @(negedge core_clk);
    sebt_ctl_model_i.start();
    addr_w({TYPE ^ 4'h8, 3'h2, 1'b0}, 1'b1, "type_nak");
    addr_w(8'h00, 1'b1, "idle_nak");
    sebt_ctl_model_i.stop();
  endtask

  // Byte write, polling while busy, then polling after the cycle.
  task automatic t_byte_write();
    clr();
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b0, "dev_ack");
    addr_w(8'hC1, 1'b0, "hi_ack");
    addr_w(8'h3E, 1'b0, "lo_ack");
    addr_w(8'h5A, 1'b0, "data_ack");
    sebt_ctl_model_i.stop();
    wait_busy(1'b1);
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b1, "poll_nak");
    sebt_ctl_model_i.stop();
    wait_busy(1'b0);
    check("prog_len", 16'(busy_len), 16'(PROG));
    check("wr_cnt", 16'(wr_cnt), 16'h0001);
    check("wr_data", 16'(wr_mem[15'h413E]), 16'h005A);
    repeat (20) @(negedge core_clk);
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b0, "poll_ack");
    sebt_ctl_model_i.stop();
  endtask

  // 65 bytes from offset 3E: the last one wraps onto the first.
  task automatic t_page_wrap();
    logic [5:0] i;
    clr();
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b0, "dev_ack");
    addr_w(8'h12, 1'b0, "hi_ack");
    addr_w(8'h7E, 1'b0, "lo_ack");
    for (int k = 0; k < 65; k++) begin
      addr_w(8'(k + 1), 1'b0, "page_ack");
    end
    sebt_ctl_model_i.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    check("page_cnt", 16'(wr_cnt), 16'h0040);
    check("page_len", 16'(busy_len), 16'(PROG));
    for (int o = 0; o < 64; o++) begin
      i = 6'(o) - 6'h3E;
      check("page_data", 16'(wr_mem[{9'h049, 6'(o)}]),
            (i == 6'h00) ? 16'h0041 : 16'(i) + 16'h0001);
    end
  endtask

  // Locked: addresses acknowledged, data refused, nothing programmed.
  task automatic t_lock();
    clr();
    @(negedge core_clk) write_lock = 1'b1;
    repeat (5) @(negedge core_clk);
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b0, "lk_dev_ack");
    addr_w(8'h00, 1'b0, "lk_hi_ack");
    addr_w(8'h10, 1'b0, "lk_lo_ack");
    addr_w(8'hA5, 1'b1, "lk_data_nak");
    sebt_ctl_model_i.stop();
    repeat (50) @(negedge core_clk);
    check("lk_busy", 16'(prog_busy), 16'h0000);
    check("lk_wr_cnt", 16'(wr_cnt), 16'h0000);
    @(negedge core_clk) write_lock = 1'b0;
  endtask

  // Dummy write to 7FFE, then a read across the top of the array.
  task automatic t_read();
    logic [7:0] d;
    logic s;
    clr();
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b0}, 1'b0, "dev_ack");
    addr_w(8'hFF, 1'b0, "hi_ack");
    addr_w(8'hFE, 1'b0, "lo_ack");
    sebt_ctl_model_i.start();
    addr_w({TYPE, 3'h2, 1'b1}, 1'b0, "rd_dev_ack");
    for (int k = 0; k < 3; k++) begin
      sebt_ctl_model_i.rd_byte(k == 2, d, s);
      check("rd_data", 16'(d), 16'(rd_val(15'(32'h7FFE + k))));
      check("rd_ack_line", 16'(s), 16'(k == 2));
    end
    sebt_ctl_model_i.stop();
    repeat (20) @(negedge core_clk);
    check("rd_busy", 16'(prog_busy), 16'h0000);
    check("rd_wr_cnt", 16'(wr_cnt), 16'h0000);
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    write_lock = 1'b0;
    select_strap_pins = 3'h2;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    repeat (10) @(negedge core_clk);
    check("idle_released", 16'(sda_oen), 16'h0001);
    t_select();
    t_byte_write();
    t_page_wrap();
    t_lock();
    t_read();
    end_sim();
  end

  // The scenarios need about 3 ms; 6 ms means something hung.
  initial begin
    #(6_000_000);
    miscompares++;
    end_sim();
  end
endmodule
